/* File: core/mxe_exec.sv */
// exec unit: byte/bit set, skips, subtract, swap, table read, xor
`timescale 1ns/10ps

// Functional notes
// - set byte writes FFH, flags untouched
// - set bit forces one bit only
// - increment memory, skip when sum zero
// - increment into accumulator, skip on zero
// - skip when selected bit is one
// - memory subtract acc+~m+1, four flags
// - immediate subtract acc+~x+1, four flags
// - swap nibbles of memory byte in place
// - swapped byte to accumulator, memory kept
// - skip when memory byte is zero
// - copy byte to accumulator, skip if zero
// - skip when selected bit is zero
// - table read current page, low/high split
// - table read last page, low/high split
// - xor memory into accumulator, zero only
// - xor into memory, zero flag only
// - xor immediate into accumulator, zero only
module mxe_exec (
    // clock and reset
    input wire logic mclk_in,
    input wire logic rst_n_in,
    // instruction request
    input wire logic issue_in,
    input mxe_pkg::mxe_req_t req_in,
    // table read support
    input wire logic [7:0] table_pointer_in,
    input wire logic [9:0] pc_in,
    input wire logic [13:0] rom_data_in,
    // results
    output mxe_pkg::mxe_mem_wr_t mem_wr_out,
    output logic [7:0] acc_out,
    output mxe_pkg::mxe_flags_t flags_out,
    output logic [5:0] table_high_latch_out,
    output logic [9:0] rom_addr_out,
    output logic rom_rd_out,
    output logic busy_out,
    output logic skip_out
);
    import mxe_pkg::*;

    // ===========================================================
    // state record
    typedef struct packed {
        mxe_state_t st;
        logic [7:0] acc;
        mxe_flags_t flags;
        logic [5:0] table_high_latch;
        mxe_mem_wr_t wr;
        logic [9:0] rom_addr;
        logic rom_rd;
        logic skip;
    } mxe_regs_t;

    mxe_regs_t cur_ff;
    mxe_regs_t nxt_cur;

    // a + ~b + 1 with carry, half carry and signed wrap
    function automatic logic [11:0] sub_calc(input logic [7:0] a,
                                             input logic [7:0] b);
        logic [8:0] sum;
        logic [4:0] low;
        logic ov;
        sum = {1'b0, a} + {1'b0, ~b} + 9'h001;
        low = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + 5'h01;
        ov = (a[7] != b[7]) && (sum[7] != a[7]);
        sub_calc = {ov, low[4], sum[8], 1'b0, sum[7:0]};
    endfunction

    function automatic logic [7:0] nib_swap(input logic [7:0] v);
        nib_swap = {v[3:0], v[7:4]};
    endfunction

    // ===========================================================
    // next-state logic
    always_comb begin
        logic [11:0] sr;
        logic [7:0] inc;
        logic [7:0] xr;
        logic bitv;
        sr = sub_calc(cur_ff.acc, req_in.op == OP_SUB_IMM ?
                      req_in.imm_data : req_in.mem_data);
        inc = req_in.mem_data + 8'h01;
        xr = cur_ff.acc ^ (req_in.op == OP_XOR_IMM ?
                           req_in.imm_data : req_in.mem_data);
        bitv = req_in.mem_data[req_in.bit_sel];
        nxt_cur = cur_ff;
        // write strobe and skip are single-cycle pulses
        nxt_cur.wr.wr_en = 1'b0;
        nxt_cur.rom_rd = 1'b0;
        nxt_cur.skip = 1'b0;
        case (cur_ff.st)
            ST_IDLE: begin
                if (issue_in) begin
                    case (req_in.op)
                        OP_SET_BYTE: begin
                            nxt_cur.wr = '{1'b1, BYTE_ALL_ONES};
                        end
                        OP_SET_BIT: begin
                            nxt_cur.wr.wr_en = 1'b1;
                            nxt_cur.wr.wr_data = req_in.mem_data;
                            nxt_cur.wr.wr_data[req_in.bit_sel] = 1'b1;
                        end
                        OP_INC_SKIP_Z: begin
                            nxt_cur.wr = '{1'b1, inc};
                            if (inc == BYTE_ZERO) begin
                                nxt_cur.st = ST_DUMMY;
                                nxt_cur.skip = 1'b1;
                            end
                        end
                        OP_INC_W_SKIP_Z: begin
                            nxt_cur.acc = inc;
                            if (inc == BYTE_ZERO) begin
                                nxt_cur.st = ST_DUMMY;
                                nxt_cur.skip = 1'b1;
                            end
                        end
                        OP_SKIP_BIT_SET: begin
                            if (bitv) begin
                                nxt_cur.st = ST_DUMMY;
                                nxt_cur.skip = 1'b1;
                            end
                        end
                        OP_SUB_MEM, OP_SUB_INTO_MEM, OP_SUB_IMM: begin
                            if (req_in.op == OP_SUB_INTO_MEM) begin
                                nxt_cur.wr = '{1'b1, sr[7:0]};
                            end else begin
                                nxt_cur.acc = sr[7:0];
                            end
                            nxt_cur.flags.c = sr[9];
                            nxt_cur.flags.ac = sr[10];
                            nxt_cur.flags.ov = sr[11];
                            nxt_cur.flags.z = (sr[7:0] == BYTE_ZERO);
                        end
                        OP_NIB_SWAP: begin
                            nxt_cur.wr = '{1'b1,
                                           nib_swap(req_in.mem_data)};
                        end
                        OP_NIB_SWAP_W: begin
                            nxt_cur.acc = nib_swap(req_in.mem_data);
                        end
                        OP_SKIP_Z, OP_MOVE_SKIP_Z: begin
                            if (req_in.op == OP_MOVE_SKIP_Z) begin
                                nxt_cur.acc = req_in.mem_data;
                            end
                            if (req_in.mem_data == BYTE_ZERO) begin
                                nxt_cur.st = ST_DUMMY;
                                nxt_cur.skip = 1'b1;
                            end
                        end
                        OP_SKIP_BIT_CLR: begin
                            if (!bitv) begin
                                nxt_cur.st = ST_DUMMY;
                                nxt_cur.skip = 1'b1;
                            end
                        end
                        OP_TAB_CUR: begin
                            // page bits from the program counter
                            nxt_cur.rom_addr = {pc_in[9:8],
                                                table_pointer_in};
                            nxt_cur.rom_rd = 1'b1;
                            nxt_cur.st = ST_TABLE;
                        end
                        OP_TAB_LAST: begin
                            nxt_cur.rom_addr = {LAST_PAGE,
                                                table_pointer_in};
                            nxt_cur.rom_rd = 1'b1;
                            nxt_cur.st = ST_TABLE;
                        end
                        OP_XOR_MEM, OP_XOR_IMM: begin
                            nxt_cur.acc = xr;
                            nxt_cur.flags.z = (xr == BYTE_ZERO);
                        end
                        OP_XOR_INTO_MEM: begin
                            nxt_cur.wr = '{1'b1, xr};
                            nxt_cur.flags.z = (xr == BYTE_ZERO);
                        end
                        default: begin
                            nxt_cur.st = ST_IDLE;
                        end
                    endcase
                end
            end
            ST_TABLE: begin
                // rom word arrives one cycle after the address
                nxt_cur.wr = '{1'b1, rom_data_in[7:0]};
                nxt_cur.table_high_latch = rom_data_in[13:8];
                nxt_cur.st = ST_IDLE;
            end
            ST_DUMMY: begin
                // discarded prefetch slot; requests here are ignored
                nxt_cur.st = ST_IDLE;
            end
            default: begin
                nxt_cur.st = ST_IDLE;
            end
        endcase
    end

    // ===========================================================
    // state register
    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            cur_ff <= '{ST_IDLE, ACC_RST, FLAGS_RST, TABLE_HIGH_LATCH_RST,
                        '{1'b0, BYTE_ZERO}, 10'h000, 1'b0, 1'b0};
        end else begin
            cur_ff <= nxt_cur;
        end
    end

    // outputs straight from flip-flops, except busy_out, which is decoded from the state field
    assign mem_wr_out = cur_ff.wr;
    assign acc_out = cur_ff.acc;
    assign flags_out = cur_ff.flags;
    assign table_high_latch_out = cur_ff.table_high_latch;
    assign rom_addr_out = cur_ff.rom_addr;
    assign rom_rd_out = cur_ff.rom_rd;
    assign busy_out = (cur_ff.st != ST_IDLE);
    assign skip_out = cur_ff.skip;
endmodule

/* File: core/mxe_pkg.sv */
// package: opcodes, flag layout, reset values and timing for the exec unit
package mxe_pkg;
    // ===========================================================
    // operation selects
    typedef enum logic [4:0] {
        OP_NOP = 5'h00,
        OP_SET_BYTE = 5'h01,
        OP_SET_BIT = 5'h02,
        OP_INC_SKIP_Z = 5'h03,
        OP_INC_W_SKIP_Z = 5'h04,
        OP_SKIP_BIT_SET = 5'h05,
        OP_SUB_MEM = 5'h06,
        OP_SUB_INTO_MEM = 5'h07,
        OP_SUB_IMM = 5'h08,
        OP_NIB_SWAP = 5'h09,
        OP_NIB_SWAP_W = 5'h0A,
        OP_SKIP_Z = 5'h0B,
        OP_MOVE_SKIP_Z = 5'h0C,
        OP_SKIP_BIT_CLR = 5'h0D,
        OP_TAB_CUR = 5'h0E,
        OP_TAB_LAST = 5'h0F,
        OP_XOR_MEM = 5'h10,
        OP_XOR_INTO_MEM = 5'h11,
        OP_XOR_IMM = 5'h12
    } mxe_op_t;

    // ===========================================================
    // execution states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_TABLE = 2'b01,
        ST_DUMMY = 2'b10
    } mxe_state_t;

    // ===========================================================
    // constants
    localparam int DATA_W = 8;
    localparam int ROM_W = 14;
    localparam int ROM_ADDR_W = 10;
    localparam int TABLE_HIGH_LATCH_W = 6;
    localparam logic [7:0] BYTE_ALL_ONES = 8'hFF;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [7:0] ACC_RST = 8'h00;
    localparam logic [5:0] TABLE_HIGH_LATCH_RST = 6'h00;
    localparam logic [2:0] PAGE_HI_W = 3'h2;
    localparam logic [1:0] LAST_PAGE = 2'h3;
    // flag bit positions in the packed flag word
    localparam int FLAG_C = 0;
    localparam int FLAG_AC = 1;
    localparam int FLAG_Z = 2;
    localparam int FLAG_OV = 3;
    localparam logic [3:0] FLAGS_RST = 4'h0;
    localparam int SKIP_CYCLES = 2;
    localparam int PLAIN_CYCLES = 1;

    // ===========================================================
    // request and result carriers
    typedef struct packed {
        mxe_op_t op;
        logic [7:0] mem_data;
        logic [7:0] imm_data;
        logic [2:0] bit_sel;
    } mxe_req_t;

    typedef struct packed {
        logic wr_en;
        logic [7:0] wr_data;
    } mxe_mem_wr_t;

    typedef struct packed {
        logic ov;
        logic z;
        logic ac;
        logic c;
    } mxe_flags_t;
endpackage

/* File: dv/mxe_exec_monitor.sv */
// checker: timing and result relations at the exec unit ports
`timescale 1ns/10ps
module mxe_exec_monitor (
    // clock and reset
    input wire logic mclk_in,
    input wire logic rst_n_in,
    // requests
    input wire logic issue_in,
    input mxe_pkg::mxe_req_t req_in,
    input wire logic [7:0] table_pointer_in,
    input wire logic [9:0] pc_in,
    input wire logic [13:0] rom_data_in,
    // results
    input mxe_pkg::mxe_mem_wr_t mem_wr_out,
    input wire logic [7:0] acc_out,
    input mxe_pkg::mxe_flags_t flags_out,
    input wire logic [5:0] table_high_latch_out,
    input wire logic [9:0] rom_addr_out,
    input wire logic rom_rd_out,
    input wire logic busy_out,
    input wire logic skip_out
);
    import mxe_pkg::*;
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rst_n_in);
    // ==========================================================
    // helpers
    wire logic taken = issue_in && !busy_out;
    wire logic [8:0] sub_imm = {1'b0, acc_out}
        + {1'b0, ~req_in.imm_data} + 9'h001;
    // ==========================================================
    // sequences
    sequence tab_fetch(logic [1:0] pg);
        rom_rd_out && busy_out
            && rom_addr_out == {pg, $past(table_pointer_in)};
    endsequence
    sequence tab_store;
        mem_wr_out.wr_en && !busy_out
            && mem_wr_out.wr_data == $past(rom_data_in[7:0])
            && table_high_latch_out == $past(rom_data_in[13:8]);
    endsequence
    // ==========================================================
    // assertions
    chk_skip_dummy_slot: assert property (skip_out |-> busy_out ##1
        (!busy_out && !skip_out && !mem_wr_out.wr_en))
        else $error("skip not followed by one dummy cycle");
    chk_set_byte_ones: assert property (taken && req_in.op == OP_SET_BYTE
        |=> mem_wr_out.wr_en && mem_wr_out.wr_data == BYTE_ALL_ONES
        && $stable(flags_out)) else $error("set byte wrong");
    chk_sub_imm_result: assert property (taken && req_in.op == OP_SUB_IMM
        |=> acc_out == $past(sub_imm[7:0]) && flags_out.c == $past(sub_imm[8]))
        else $error("immediate subtract wrong");
    chk_xor_zero_only: assert property (taken && req_in.op == OP_XOR_MEM
        |=> acc_out == $past(acc_out ^ req_in.mem_data)
        && flags_out.z == (acc_out == 8'h00) && flags_out.c == $past(flags_out.c)
        && flags_out.ov == $past(flags_out.ov)) else $error("xor wrong");
    chk_swap_in_place: assert property (taken && req_in.op == OP_NIB_SWAP
        |=> mem_wr_out.wr_en && $stable(acc_out) && mem_wr_out.wr_data ==
        {$past(req_in.mem_data[3:0]), $past(req_in.mem_data[7:4])})
        else $error("nibble swap wrong");
    chk_tab_last_seq: assert property (taken && req_in.op == OP_TAB_LAST
        |=> tab_fetch(LAST_PAGE) ##1 tab_store) else $error("last page read");
    chk_tab_cur_seq: assert property (taken && req_in.op == OP_TAB_CUR
        |=> tab_fetch($past(pc_in[9:8])) ##1 tab_store)
        else $error("current page read wrong");
    chk_skip_zero_cause: assert property (taken && req_in.op == OP_SKIP_Z
        |=> skip_out == $past(req_in.mem_data == BYTE_ZERO)
        && !mem_wr_out.wr_en) else $error("skip if zero wrong");
endmodule

/* File: dv/tb.sv */
// testbench: random operand sweep of every operation with a result queue
`timescale 1ns/10ps
module tb;
    import mxe_pkg::*;
    typedef struct packed {int at; logic [27:0] v;} mxe_note_t;
    logic mclk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic issue_in = 1'b0;
    mxe_req_t req_in = '0;
    logic [7:0] table_pointer_in = 8'h00;
    logic [9:0] pc_in = 10'h000;
    logic [13:0] rom_data_in = 14'h0000;
    mxe_mem_wr_t mem_wr_out;
    mxe_flags_t flags_out;
    logic [7:0] acc_out;
    logic [5:0] table_high_latch_out;
    logic [9:0] rom_addr_out;
    logic rom_rd_out, busy_out, skip_out;
    int seed = 63529;
    int cyc = 0;
    int mismatches = 0;
    int checks = 0;
    logic [7:0] acc_m;
    mxe_flags_t fl_m;
    logic [5:0] th_m;
    logic [27:0] obs;
    mxe_note_t nt;
    mxe_note_t q[$];
    mxe_exec i_dut (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
        .issue_in(issue_in), .req_in(req_in),
        .table_pointer_in(table_pointer_in), .pc_in(pc_in),
        .rom_data_in(rom_data_in), .mem_wr_out(mem_wr_out),
        .acc_out(acc_out), .flags_out(flags_out),
        .table_high_latch_out(table_high_latch_out),
        .rom_addr_out(rom_addr_out), .rom_rd_out(rom_rd_out),
        .busy_out(busy_out), .skip_out(skip_out));
    // ==========================================================
    // clock and hang guard
    always #50 mclk_in = ~mclk_in;
    always @(posedge mclk_in) begin
        cyc <= cyc + 1;
        if (cyc > 6000) begin
            mismatches++;
            final_report();
        end
    end
    // ==========================================================
    // watcher: wr_data only means something while wr_en is high
    always @(negedge mclk_in) begin
        if (q.size() > 0 && q[0].at == cyc) begin
            nt = q.pop_front();
            obs = {mem_wr_out.wr_en, mem_wr_out.wr_data & {8{mem_wr_out.wr_en}},
                acc_out, flags_out, table_high_latch_out, skip_out};
            checks++;
            if (obs !== nt.v) begin
                mismatches++;
                $display("[ERR] t=%0t got %h exp %h", $time, obs, nt.v);
            end
        end
    end
    // ==========================================================
    // driver tasks
    task note(input int at, input logic we, input logic [7:0] wd,
        input logic sk);
        q.push_back('{at, {we, wd, acc_m, fl_m, th_m, sk}});
    endtask
    task do_reset();
        rst_n_in = 1'b0;
        issue_in = 1'b0;
        repeat (2) @(posedge mclk_in);
        #1;
        acc_m = ACC_RST;
        fl_m = FLAGS_RST;
        th_m = TABLE_HIGH_LATCH_RST;
        note(cyc, 1'b0, 8'h00, 1'b0);
        rst_n_in = 1'b1;
        @(posedge mclk_in);
        #1;
    endtask
    task exec(input mxe_op_t op);
        logic [7:0] m, x, s, wd;
        logic [8:0] r9;
        logic [4:0] h5;
        logic we, sk;
        m = $random(seed);
        x = $random(seed);
        if (x[1:0] == 2'h0) m = 8'h00;
        if (x[1:0] == 2'h1) m = 8'hFF;
        req_in = '{op, m, $random(seed), $random(seed)};
        table_pointer_in = $random(seed);
        pc_in = $random(seed);
        rom_data_in = $random(seed);
        x = req_in.imm_data;
        we = 1'b0;
        wd = 8'h00;
        sk = 1'b0;
        case (op)
            OP_SET_BYTE: {we, wd} = {1'b1, 8'hFF};
            OP_SET_BIT: {we, wd} = {1'b1, m | (8'h01 << req_in.bit_sel)};
            OP_INC_SKIP_Z: {we, wd, sk} = {1'b1, m + 8'h01, m == 8'hFF};
            OP_INC_W_SKIP_Z: {acc_m, sk} = {m + 8'h01, m == 8'hFF};
            OP_SKIP_BIT_SET: sk = m[req_in.bit_sel];
            OP_SUB_MEM, OP_SUB_INTO_MEM, OP_SUB_IMM: begin
                s = (op == OP_SUB_IMM) ? x : m;
                r9 = {1'b0, acc_m} + {1'b0, ~s} + 9'h001;
                h5 = {1'b0, acc_m[3:0]} + {1'b0, ~s[3:0]} + 5'h01;
                fl_m = '{(acc_m[7] != s[7]) && (r9[7] != acc_m[7]),
                    r9[7:0] == 8'h00, h5[4], r9[8]};
                if (op == OP_SUB_INTO_MEM) {we, wd} = {1'b1, r9[7:0]};
                else acc_m = r9[7:0];
            end
            OP_NIB_SWAP: {we, wd} = {1'b1, m[3:0], m[7:4]};
            OP_NIB_SWAP_W: acc_m = {m[3:0], m[7:4]};
            OP_SKIP_Z: sk = (m == 8'h00);
            OP_MOVE_SKIP_Z: {acc_m, sk} = {m, m == 8'h00};
            OP_SKIP_BIT_CLR: sk = !m[req_in.bit_sel];
            OP_TAB_CUR, OP_TAB_LAST: begin
                {we, wd, th_m} = {1'b1, rom_data_in[7:0], rom_data_in[13:8]};
            end
            OP_XOR_MEM, OP_XOR_IMM: begin
                acc_m = acc_m ^ ((op == OP_XOR_IMM) ? x : m);
                fl_m.z = (acc_m == 8'h00);
            end
            OP_XOR_INTO_MEM: begin
                {we, wd} = {1'b1, acc_m ^ m};
                fl_m.z = (wd == 8'h00);
            end
            default: ;
        endcase
        issue_in = 1'b1;
        if (op == OP_TAB_CUR || op == OP_TAB_LAST) note(cyc + 2, we, wd, sk);
        else note(cyc + 1, we, wd, sk);
        // dummy slot: a request offered while busy must be ignored
        if (sk) note(cyc + 2, 1'b0, 8'h00, 1'b0);
        @(posedge mclk_in);
        #1;
        if (sk || op == OP_TAB_CUR || op == OP_TAB_LAST) begin
            req_in.op = OP_SET_BYTE;
            @(posedge mclk_in);
            #1;
        end
    endtask
    // ==========================================================
    // main sequence, with a reset in mid-run
    initial begin
        do_reset();
        for (int r = 0; r < 40; r++) begin
            if (r == 20) do_reset();
            for (int i = 0; i < 19; i++) exec(mxe_op_t'(i[4:0]));
        end
        issue_in = 1'b0;
        repeat (4) @(posedge mclk_in);
        final_report();
    end
    task final_report();
        if (mismatches == 0 && checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
endmodule
bind mxe_exec mxe_exec_monitor i_mon (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
    .issue_in(issue_in), .req_in(req_in),
    .table_pointer_in(table_pointer_in), .pc_in(pc_in),
    .rom_data_in(rom_data_in), .mem_wr_out(mem_wr_out), .acc_out(acc_out),
    .flags_out(flags_out), .table_high_latch_out(table_high_latch_out),
    .rom_addr_out(rom_addr_out), .rom_rd_out(rom_rd_out),
    .busy_out(busy_out), .skip_out(skip_out));
